// ---- bench/nidpct_assertions.sv ----
// Concurrent checks on the link between host registers and PHY core
`timescale 1ns/1ps
module nidpct_assertions #(
	parameter int TICK_DIV = 8
) (
	input wire logic                                aclk,
	input wire logic                                aresetn,
	input wire logic                                req_valid,
	input wire nidpct_pkg::nidpct_req_t             req_kind,
	input wire logic [nidpct_pkg::PHY_ADDR_W-1:0]   req_addr,
	input wire logic                                req_ready,
	input wire logic                                xfer_valid,
	input wire logic [nidpct_pkg::PHY_ADDR_W-1:0]   xfer_addr,
	input wire logic                                tick_24m,
	input wire logic                                is_root,
	input wire logic                                cs_tx_valid,
	input wire logic [nidpct_pkg::DATA_W-1:0]       cs_tx_data
);
	import nidpct_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	int unsigned tick_gap;
	logic        tick_seen;
	always_ff @(posedge aclk) begin
		if (!aresetn || tick_24m) begin
			tick_gap <= 0;
		end else begin
			tick_gap <= tick_gap + 1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_seen <= 1'b0;
		end else if (tick_24m) begin
			tick_seen <= 1'b1;
		end
	end
	req_kind_a: assert property (req_valid |-> req_kind inside {NIDPCT_REQ_READ, NIDPCT_REQ_WRITE})
		else $error("request without a kind");
	req_once_a: assert property (req_valid && req_ready |=> !req_valid)
		else $error("request not cleared after send");
	read_answer_a: assert property (req_valid && req_ready && req_kind == NIDPCT_REQ_READ
		|=> xfer_valid && xfer_addr == $past(req_addr)) else $error("read not answered");
	xfer_cause_a: assert property (xfer_valid
		|-> $past(req_valid && req_ready && req_kind == NIDPCT_REQ_READ)) else $error("stray transfer");
	xfer_pulse_a: assert property (xfer_valid |=> !xfer_valid)
		else $error("transfer longer than a cycle");
	tx_pulse_a: assert property (cs_tx_valid |=> !cs_tx_valid)
		else $error("cycle start longer than a cycle");
	tx_root_a: assert property (cs_tx_valid |-> $past(is_root))
		else $error("cycle start sent while not root");
	tx_range_a: assert property (cs_tx_valid
		|-> cs_tx_data[24:12] <= CT_CYC_LAST && cs_tx_data[11:0] <= CT_OFF_LAST)
		else $error("cycle start fields out of range");
	tick_rate_a: assert property (tick_24m && tick_seen |-> tick_gap == TICK_DIV - 1)
		else $error("timer tick spacing wrong");
	read_req_c: cover property (req_valid && req_kind == NIDPCT_REQ_READ);
	write_req_c: cover property (req_valid && req_kind == NIDPCT_REQ_WRITE);
	cycle_start_c: cover property (cs_tx_valid);
endmodule

// ---- bench/tb_node_id_phy_access_cycle_timer.sv ----
// Self-checking bench for the host register end joined to the PHY core end
`timescale 1ns/1ps
module tb_node_id_phy_access_cycle_timer;
	import nidpct_pkg::*;
	typedef struct {
		logic        wr;
		logic [11:0] addr;
		logic [31:0] data;
		logic [31:0] exp;
		logic [1:0]  resp;
	} nidpct_row_t;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b1;
	logic [11:0] s_axi_araddr = 12'h0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b1;
	logic [15:0] node_identifier;
	logic        bus_reset_in = 1'b0;
	logic        node_valid_in = 1'b0;
	logic [5:0]  node_index_in = 6'h0;
	logic        is_root_in = 1'b0;
	logic        cable_power_in = 1'b0;
	logic        tick_8k_in = 1'b0;
	logic        cs_rx_valid_in = 1'b0;
	logic [31:0] cs_rx_data_in = 32'h0;
	logic        cs_tx_seen;
	logic [31:0] cs_tx_last;
	logic [31:0] t1;
	logic [31:0] t2;
	logic [1:0]  rsp;
	int          n_errors = 0;
	int          total_checks = 0;
	nidpct_row_t rows [10];
	nidpct_if bus ();
	nidpct_link #(.EXT_8K(1'b1)) u_nidpct_link (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .node_identifier, .phy(bus));
	nidpct_phy #(.TICK_DIV(8)) u_nidpct_phy (.aclk, .aresetn, .bus_reset_in, .node_valid_in,
		.node_index_in, .is_root_in, .cable_power_in, .tick_8k_in, .cs_rx_valid_in,
		.cs_rx_data_in, .cs_tx_seen, .cs_tx_last, .link(bus));
	nidpct_assertions #(.TICK_DIV(8)) u_nidpct_assertions (.aclk, .aresetn,
		.req_valid(bus.req_valid), .req_kind(bus.req_kind), .req_addr(bus.req_addr),
		.req_ready(bus.req_ready), .xfer_valid(bus.xfer_valid), .xfer_addr(bus.xfer_addr),
		.tick_24m(bus.tick_24m), .is_root(bus.is_root), .cs_tx_valid(bus.cs_tx_valid),
		.cs_tx_data(bus.cs_tx_data));
	always #2.5 aclk = ~aclk;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic hang(input string what);
		n_errors++;
		$display("MISMATCH t=%0t timeout %s", $time, what);
		end_sim();
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
		total_checks++;
		if (((got ^ exp) & mask) !== 32'h0) begin
			n_errors++;
			$display("MISMATCH t=%0t data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t response %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (i == 50) hang("write");
		r = s_axi_bresp;
	endtask
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (i == 50) hang("read");
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_resp(r, RESP_OKAY);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		chk32(d, exp, mask);
		chk_resp(r, RESP_OKAY);
	endtask
	initial begin
		int i;
		rows = '{
			'{1'b1, OFF_NODE_ID, 32'hffffffff, 32'h0, RESP_OKAY},
			'{1'b0, OFF_NODE_ID, 32'h0, 32'h0000ffff, RESP_OKAY},
			'{1'b1, OFF_NODE_ID, 32'h00005540, 32'h0, RESP_OKAY},
			'{1'b0, OFF_NODE_ID, 32'h0, 32'h0000557f, RESP_OKAY},
			'{1'b1, OFF_PHY_ACCESS, 32'h70003abc, 32'h0, RESP_OKAY},
			'{1'b0, OFF_PHY_ACCESS, 32'h0, 32'h00000abc, RESP_OKAY},
			'{1'b1, OFF_CYCLE_TIMER, 32'hfe000123, 32'h0, RESP_OKAY},
			'{1'b0, OFF_CYCLE_TIMER, 32'h0, 32'hfe000123, RESP_OKAY},
			'{1'b1, 12'h004, 32'h12345678, 32'h0, RESP_SLVERR},
			'{1'b0, 12'h004, 32'h0, 32'h0, RESP_SLVERR}};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 10; i++) begin
			if (rows[i].wr) begin
				axi_wr(rows[i].addr, rows[i].data, rsp);
			end else begin
				axi_rd(rows[i].addr, t1, rsp);
				chk32(t1, rows[i].exp, 32'hffffffff);
			end
			chk_resp(rsp, rows[i].resp);
		end
		chk32({16'h0, node_identifier}, 32'h557f, 32'hffff);
		$display("test register table done");
		is_root_in <= 1'b1;
		cable_power_in <= 1'b1;
		node_index_in <= 6'h05;
		bus_reset_in <= 1'b1;
		@(posedge aclk);
		bus_reset_in <= 1'b0;
		node_valid_in <= 1'b1;
		@(posedge aclk);
		node_valid_in <= 1'b0;
		repeat (3) @(posedge aclk);
		rd_chk(OFF_NODE_ID, 32'hc8005545, 32'hffffffff);
		chk32({16'h0, node_identifier}, 32'h5545, 32'hffff);
		bus_reset_in <= 1'b1;
		@(posedge aclk);
		bus_reset_in <= 1'b0;
		repeat (3) @(posedge aclk);
		rd_chk(OFF_NODE_ID, 32'h0, 32'h80000000);
		$display("test node status done");
		wr(OFF_PHY_ACCESS, 32'h0000455a);
		repeat (4) @(posedge aclk);
		rd_chk(OFF_PHY_ACCESS, 32'h0000055a, 32'hffffffff);
		wr(OFF_PHY_ACCESS, 32'h00008500);
		repeat (4) @(posedge aclk);
		rd_chk(OFF_PHY_ACCESS, 32'h855a0500, 32'hffffffff);
		wr(OFF_PHY_ACCESS, 32'h00004600);
		repeat (4) @(posedge aclk);
		rd_chk(OFF_PHY_ACCESS, 32'h055a0600, 32'hffffffff);
		$display("test phy access done");
		wr(OFF_CYCLE_TIMER, 32'hfff3fbfe);
		wr(OFF_LINK_CTRL, 32'h00100000);
		repeat (40) @(posedge aclk);
		rd_chk(OFF_CYCLE_TIMER, 32'h0, 32'hfffff000);
		wr(OFF_CYCLE_TIMER, 32'h12345abc);
		tick_8k_in <= 1'b1;
		@(posedge aclk);
		tick_8k_in <= 1'b0;
		rd_chk(OFF_CYCLE_TIMER, 32'h12000000, 32'hfe000800);
		wr(OFF_LINK_CTRL, 32'h0);
		axi_rd(OFF_CYCLE_TIMER, t1, rsp);
		repeat (40) @(posedge aclk);
		axi_rd(OFF_CYCLE_TIMER, t2, rsp);
		chk32(t2, t1, 32'hffffffff);
		cs_rx_data_in <= 32'h12345000;
		cs_rx_valid_in <= 1'b1;
		@(posedge aclk);
		cs_rx_valid_in <= 1'b0;
		repeat (2) @(posedge aclk);
		rd_chk(OFF_CYCLE_TIMER, 32'h12345000, 32'hffffffff);
		wr(OFF_CYCLE_TIMER, 32'h12345bf4);
		wr(OFF_LINK_CTRL, 32'h00300000);
		for (i = 0; i < 400 && cs_tx_seen !== 1'b1; i++) @(posedge aclk);
		if (i == 400) hang("cycle start");
		@(posedge aclk);
		chk32(cs_tx_last, 32'h12346000, 32'hfffff000);
		wr(OFF_LINK_CTRL, 32'h0);
		$display("test cycle timer done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(OFF_NODE_ID, 32'h0000ffff, 32'h8000ffff);
		rd_chk(OFF_PHY_ACCESS, 32'h0, 32'hffffffff);
		chk32({16'h0, node_identifier}, 32'hffff, 32'hffff);
		$display("test second reset done");
		end_sim();
	end
endmodule

// ---- hdl/nidpct_if.sv ----
// Link between the host controller registers and the PHY core side
`timescale 1ns/1ps
interface nidpct_if;
	import nidpct_pkg::*;
	// Register request toward the PHY core
	logic                    req_valid;
	nidpct_req_t             req_kind;
	logic [PHY_ADDR_W-1:0]   req_addr;
	logic [PHY_DATA_W-1:0]   req_data;
	logic                    req_ready;
	// Register transfer back from the PHY core
	logic                    xfer_valid;
	logic [PHY_ADDR_W-1:0]   xfer_addr;
	logic [PHY_DATA_W-1:0]   xfer_data;
	// Node status
	logic                    bus_reset;
	logic                    node_valid;
	logic [NID_NODE_W-1:0]   node_index;
	logic                    is_root;
	logic                    cable_power;
	// Cycle timing
	logic                    tick_24m;
	logic                    tick_8k;
	logic                    cs_rx_valid;
	logic [DATA_W-1:0]       cs_rx_data;
	logic                    cs_tx_valid;
	logic [DATA_W-1:0]       cs_tx_data;
	modport link (
		output req_valid, req_kind, req_addr, req_data, cs_tx_valid, cs_tx_data,
		input  req_ready, xfer_valid, xfer_addr, xfer_data, bus_reset, node_valid,
		input  node_index, is_root, cable_power, tick_24m, tick_8k, cs_rx_valid, cs_rx_data
	);
	modport phy (
		input  req_valid, req_kind, req_addr, req_data, cs_tx_valid, cs_tx_data,
		output req_ready, xfer_valid, xfer_addr, xfer_data, bus_reset, node_valid,
		output node_index, is_root, cable_power, tick_24m, tick_8k, cs_rx_valid, cs_rx_data
	);
endinterface

// ---- hdl/nidpct_link.sv ----
// Host controller end: AXI4-Lite registers for node identity, PHY access and cycle timer
// Behaviour
// - node valid cleared on reset, set on number
// - root flag loaded from PHY root report on bus reset
// - cable power flag follows PHY report
// - reserved bits read as zero
// - software writable ten bit bus index
// - node index loaded from PHY after identification
// - software avoids transmit contexts at node 63
// - read complete cleared on read/write request
// - PHY transfer sets done, captures address, value
// - read request sent, then bit self-clears
// - write request sent, then bit self-clears
// - software never sets both request bits
// - target address and write value fields
// - cycle master sends timer in cycle start
// - non-master reloads timer from cycle start
// - timer keeps counting without cycle start
// - seconds advance on cycle rollover, modulo 128
// - cycle index advances on offset rollover, modulo 8000
// - offset counts 24.576 MHz ticks, modulo 3072
// - external 8 kHz tick zeroes offset
// - offset holds while count enable cleared
// - bus and node index form node identifier
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module nidpct_link #(
	parameter bit EXT_8K = 1'b0
) (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic [nidpct_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [nidpct_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [nidpct_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [nidpct_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	output logic [15:0]                         node_identifier,
	nidpct_if.link                              phy
);
	import nidpct_pkg::*;

	logic                  aw_held;
	logic [ADDR_W-1:0]     aw_addr;
	logic                  w_held;
	logic [DATA_W-1:0]     w_data;
	logic [3:0]            w_strb;
	logic                  wr_fire;
	logic [DATA_W-1:0]     wmask;
	logic                  id_valid;
	logic                  root;
	logic                  cable_power_ok;
	logic [NID_BUS_W-1:0]  bus_index;
	logic [NID_NODE_W-1:0] phys_node_index;
	logic                  phy_read_complete;
	logic [3:0]            phy_readback_addr;
	logic [7:0]            phy_readback_value;
	logic                  phy_read_request;
	logic                  phy_write_request;
	logic [3:0]            phy_target_addr;
	logic [7:0]            phy_write_value;
	logic                  req_busy;
	logic [CT_SEC_W-1:0]   second_counter;
	logic [CT_CYC_W-1:0]   cycle_index;
	logic [CT_OFF_W-1:0]   tick_offset;
	logic                  timer_count_enable;
	logic                  cycle_master;
	logic [DATA_W-1:0]     node_word;
	logic [DATA_W-1:0]     phy_word;
	logic [DATA_W-1:0]     timer_word;
	logic [DATA_W-1:0]     next_phy_word;
	logic [DATA_W-1:0]     next_timer_word;
	logic [DATA_W-1:0]     next_node_word;
	logic                  off_wrap;
	logic                  cyc_wrap;

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Byte lane mask
	for (genvar i = 0; i < 4; i++) begin : g_mask
		assign wmask[i*8 +: 8] = {8{w_strb[i]}};
	end

	assign node_word  = {id_valid, root, 2'h0, cable_power_ok, 11'h000, bus_index,
		phys_node_index};
	assign phy_word   = {phy_read_complete, 3'h0, phy_readback_addr, phy_readback_value,
		phy_read_request, phy_write_request, 2'h0, phy_target_addr, phy_write_value};
	assign timer_word = {second_counter, cycle_index, tick_offset};
	assign next_phy_word   = (phy_word & ~wmask) | (w_data & wmask);
	assign next_timer_word = (timer_word & ~wmask) | (w_data & wmask);
	assign next_node_word  = (node_word & ~wmask) | (w_data & wmask);
	assign node_identifier = {bus_index, phys_node_index};

	// Write channel capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr)
				OFF_NODE_ID, OFF_PHY_ACCESS, OFF_CYCLE_TIMER, OFF_LINK_CTRL: begin
					s_axi_bresp <= RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (s_axi_araddr)
				OFF_NODE_ID: begin
					s_axi_rdata <= node_word;
				end
				OFF_PHY_ACCESS: begin
					s_axi_rdata <= phy_word;
				end
				OFF_CYCLE_TIMER: begin
					s_axi_rdata <= timer_word;
				end
				OFF_LINK_CTRL: begin
					s_axi_rdata <= DATA_W'({cycle_master, timer_count_enable}) << LC_ENABLE_BIT;
				end
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Node identity register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			id_valid        <= 1'b0;
			root            <= 1'b0;
			cable_power_ok  <= 1'b0;
			bus_index       <= BUS_INDEX_RST;
			phys_node_index <= NODE_INDEX_RST;
		end else begin
			cable_power_ok <= phy.cable_power;
			if (phy.node_valid) begin
				id_valid <= 1'b1;
			end else if (phy.bus_reset) begin
				id_valid <= 1'b0;
			end
			if (phy.bus_reset) begin
				root <= phy.is_root;
			end
			if (phy.node_valid) begin
				phys_node_index <= phy.node_index;
			end
			if (wr_fire && aw_addr == OFF_NODE_ID) begin
				bus_index <= next_node_word[NID_BUS_LSB +: NID_BUS_W];
			end
		end
	end

	// PHY access register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phy_read_complete  <= 1'b0;
			phy_readback_addr  <= 4'h0;
			phy_readback_value <= 8'h00;
			phy_read_request   <= 1'b0;
			phy_write_request  <= 1'b0;
			phy_target_addr    <= 4'h0;
			phy_write_value    <= 8'h00;
			req_busy           <= 1'b0;
		end else begin
			if (wr_fire && aw_addr == OFF_PHY_ACCESS && !req_busy) begin
				phy_target_addr   <= next_phy_word[PA_TADDR_LSB +: PHY_ADDR_W];
				phy_write_value   <= next_phy_word[PHY_DATA_W-1:0];
				phy_read_request  <= next_phy_word[PA_RD_BIT];
				phy_write_request <= next_phy_word[PA_WR_BIT];
				req_busy <= next_phy_word[PA_RD_BIT] | next_phy_word[PA_WR_BIT];
			end else if (req_busy && phy.req_ready) begin
				// read bit self-clears; write bit self-clears
				phy_read_request  <= 1'b0;
				phy_write_request <= 1'b0;
				req_busy          <= 1'b0;
			end
			if (phy.xfer_valid) begin
				phy_read_complete  <= 1'b1;
				phy_readback_addr  <= phy.xfer_addr;
				phy_readback_value <= phy.xfer_data;
			end else if (wr_fire && aw_addr == OFF_PHY_ACCESS &&
				(next_phy_word[PA_RD_BIT] | next_phy_word[PA_WR_BIT])) begin
				phy_read_complete <= 1'b0;
			end
		end
	end

	// read takes precedence if both set
	assign phy.req_valid = req_busy;
	assign phy.req_kind  = phy_read_request ? NIDPCT_REQ_READ :
		(phy_write_request ? NIDPCT_REQ_WRITE : NIDPCT_REQ_NONE);
	assign phy.req_addr  = phy_target_addr;
	assign phy.req_data  = phy_write_value;

	// Link control bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_count_enable <= 1'b0;
			cycle_master       <= 1'b0;
		end else if (wr_fire && aw_addr == OFF_LINK_CTRL && w_strb[2]) begin
			timer_count_enable <= w_data[LC_ENABLE_BIT];
			cycle_master       <= w_data[LC_MASTER_BIT];
		end
	end

	assign off_wrap = tick_offset == CT_OFF_LAST;
	assign cyc_wrap = cycle_index == CT_CYC_LAST;

	// Cycle timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			second_counter <= '0;
			cycle_index    <= '0;
			tick_offset    <= '0;
		end else if (wr_fire && aw_addr == OFF_CYCLE_TIMER) begin
			second_counter <= next_timer_word[CT_SEC_LSB +: CT_SEC_W];
			cycle_index    <= next_timer_word[CT_CYC_LSB +: CT_CYC_W];
			tick_offset    <= next_timer_word[CT_OFF_W-1:0];
		end else if (!cycle_master && phy.cs_rx_valid) begin
			second_counter <= phy.cs_rx_data[CT_SEC_LSB +: CT_SEC_W];
			cycle_index    <= phy.cs_rx_data[CT_CYC_LSB +: CT_CYC_W];
			tick_offset    <= phy.cs_rx_data[CT_OFF_W-1:0];
		end else if (EXT_8K && phy.tick_8k) begin
			tick_offset <= '0;
		end else if (timer_count_enable && phy.tick_24m) begin
			tick_offset <= off_wrap ? '0 : tick_offset + 1'b1;
			if (off_wrap) begin
				cycle_index <= cyc_wrap ? '0 : cycle_index + 1'b1;
				if (cyc_wrap) begin
					second_counter <= second_counter + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phy.cs_tx_valid <= 1'b0;
			phy.cs_tx_data  <= '0;
		end else begin
			phy.cs_tx_valid <= cycle_master && root && timer_count_enable && phy.tick_24m &&
				off_wrap;
			phy.cs_tx_data  <= {cyc_wrap ? second_counter + 1'b1 : second_counter,
				cyc_wrap ? {CT_CYC_W{1'b0}} : cycle_index + 1'b1, {CT_OFF_W{1'b0}}};
		end
	end
endmodule

// ---- hdl/nidpct_phy.sv ----
// PHY core end: small register file, node status and timing ticks
`timescale 1ns/1ps
module nidpct_phy #(
	parameter int TICK_DIV = 8
) (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic                              bus_reset_in,
	input  wire logic                              node_valid_in,
	input  wire logic [nidpct_pkg::NID_NODE_W-1:0] node_index_in,
	input  wire logic                              is_root_in,
	input  wire logic                              cable_power_in,
	input  wire logic                              tick_8k_in,
	input  wire logic                              cs_rx_valid_in,
	input  wire logic [nidpct_pkg::DATA_W-1:0]     cs_rx_data_in,
	output logic                                   cs_tx_seen,
	output logic [nidpct_pkg::DATA_W-1:0]          cs_tx_last,
	nidpct_if.phy                                  link
);
	import nidpct_pkg::*;

	logic [PHY_DATA_W-1:0] regs [2**PHY_ADDR_W];
	logic [7:0]            div;

	assign link.req_ready   = 1'b1;
	assign link.bus_reset   = bus_reset_in;
	assign link.node_valid  = node_valid_in;
	assign link.node_index  = node_index_in;
	assign link.is_root     = is_root_in;
	assign link.cable_power = cable_power_in;
	assign link.tick_8k     = tick_8k_in;
	assign link.cs_rx_valid = cs_rx_valid_in;
	assign link.cs_rx_data  = cs_rx_data_in;
	assign link.tick_24m    = div == 8'(TICK_DIV - 1);

	// Timing tick divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div <= 8'h00;
		end else begin
			div <= (div == 8'(TICK_DIV - 1)) ? 8'h00 : div + 8'h01;
		end
	end

	// Register requests: write stores, read answers next cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.xfer_valid <= 1'b0;
			link.xfer_addr  <= '0;
			link.xfer_data  <= '0;
		end else begin
			link.xfer_valid <= link.req_valid && link.req_kind == NIDPCT_REQ_READ;
			link.xfer_addr  <= link.req_addr;
			link.xfer_data  <= regs[link.req_addr];
		end
	end

	always_ff @(posedge aclk) begin
		if (link.req_valid && link.req_kind == NIDPCT_REQ_WRITE) begin
			regs[link.req_addr] <= link.req_data;
		end
	end

	// Cycle start capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cs_tx_seen <= 1'b0;
			cs_tx_last <= '0;
		end else begin
			cs_tx_seen <= link.cs_tx_valid;
			if (link.cs_tx_valid) begin
				cs_tx_last <= link.cs_tx_data;
			end
		end
	end
endmodule

// ---- hdl/nidpct_pkg.sv ----
// Shared constants and types for the node identity, PHY access and cycle timer link
package nidpct_pkg;
	localparam int          DATA_W          = 32;
	localparam int          ADDR_W          = 12;
	// Register byte offsets
	localparam logic [11:0] OFF_NODE_ID     = 12'he8;
	localparam logic [11:0] OFF_PHY_ACCESS  = 12'hec;
	localparam logic [11:0] OFF_CYCLE_TIMER = 12'hf0;
	localparam logic [11:0] OFF_LINK_CTRL   = 12'he0;
	// Node identity fields
	localparam int          NID_VALID_BIT   = 31;
	localparam int          NID_ROOT_BIT    = 30;
	localparam int          NID_CPS_BIT     = 27;
	localparam int          NID_BUS_LSB     = 6;
	localparam int          NID_BUS_W       = 10;
	localparam int          NID_NODE_W      = 6;
	localparam logic [9:0]  BUS_INDEX_RST   = 10'h3ff;
	localparam logic [5:0]  NODE_INDEX_RST  = 6'h3f;
	// PHY access fields
	localparam int          PA_DONE_BIT     = 31;
	localparam int          PA_RBADDR_LSB   = 24;
	localparam int          PA_RBVAL_LSB    = 16;
	localparam int          PA_RD_BIT       = 15;
	localparam int          PA_WR_BIT       = 14;
	localparam int          PA_TADDR_LSB    = 8;
	localparam int          PHY_ADDR_W      = 4;
	localparam int          PHY_DATA_W      = 8;
	// Cycle timer fields
	localparam int          CT_SEC_LSB      = 25;
	localparam int          CT_CYC_LSB      = 12;
	localparam int          CT_SEC_W        = 7;
	localparam int          CT_CYC_W        = 13;
	localparam int          CT_OFF_W        = 12;
	localparam logic [12:0] CT_CYC_LAST     = 13'd7999;
	localparam logic [11:0] CT_OFF_LAST     = 12'd3071;
	// Link control fields
	localparam int          LC_MASTER_BIT   = 21;
	localparam int          LC_ENABLE_BIT   = 20;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	// PHY request kinds
	typedef enum logic [1:0] {
		NIDPCT_REQ_NONE  = 2'h0,
		NIDPCT_REQ_READ  = 2'h1,
		NIDPCT_REQ_WRITE = 2'h2
	} nidpct_req_t;
endpackage
